// >>> verilog/lrx_params.svh
// Constants for the logic/return/rotate execution block
`ifndef LRX_PARAMS_SVH
`define LRX_PARAMS_SVH
`define LRX_DATA_W      8
`define LRX_ADDR_W      8
`define LRX_PC_W        13
`define LRX_ZERO_BYTE   8'h00
`define LRX_MSB         7
`define LRX_GATE_ON     1'b1
`define LRX_GATE_RST    1'b0
`define LRX_ISR_VECTOR  13'h0004
`endif

// >>> verilog/lrx_pkg.sv
// Types for the logic/return/rotate execution block
package lrx_pkg;
  typedef enum logic [3:0] {
    LRX_OP_NONE = 4'h0,
    LRX_OP_NOP  = 4'h1,
    LRX_OP_ORM  = 4'h2,
    LRX_OP_ORI  = 4'h3,
    LRX_OP_ORMM = 4'h4,
    LRX_OP_RET  = 4'h5,
    LRX_OP_RETL = 4'h6,
    LRX_OP_INTERRUPT_RETURN_OP = 4'h7,
    LRX_OP_RLM  = 4'h8
  } lrx_op_t;

  typedef enum logic [1:0] {
    LRX_ST_IDLE  = 2'b01,
    LRX_ST_WRITE = 2'b10
  } lrx_state_t;
endpackage

// >>> verilog/lrx_alu.sv
// Combinational result unit for OR and rotate-left
`timescale 1ns/1ps
`include "lrx_params.svh"
module lrx_alu #(
  parameter int DW = `LRX_DATA_W
) (
  // Operands
  input  wire logic [DW-1:0] i_acc,
  input  wire logic [DW-1:0] i_mem,
  input  wire logic [DW-1:0] i_lit,
  input  wire logic          i_use_lit,
  // Results
  output logic      [DW-1:0] o_or,
  output logic               o_zero,
  output logic      [DW-1:0] o_rol
);
  always_comb begin
    o_or   = i_acc | (i_use_lit ? i_lit : i_mem);
    o_zero = (o_or == DW'(0));
    o_rol  = {i_mem[DW-2:0], i_mem[DW-1]};
  end
endmodule

// >>> verilog/lrx_exec.sv
// Execution unit for NOP, OR forms, returns and rotate-left
`timescale 1ns/1ps
`include "lrx_params.svh"
module lrx_exec #(
  parameter int DW = `LRX_DATA_W,
  parameter int AW = `LRX_ADDR_W,
  parameter int PW = `LRX_PC_W
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_arst_n,
  // Decoded instruction
  input  wire logic          i_valid,
  input  wire logic [3:0]    i_op,
  input  wire logic [DW-1:0] i_lit,
  input  wire logic [AW-1:0] i_addr,
  // Core state inputs
  input  wire logic [DW-1:0] i_acc,
  input  wire logic [DW-1:0] i_mem_rdata,
  input  wire logic [PW-1:0] i_stack_top,
  input  wire logic          i_irq_pending,
  // Accumulator and flag update
  output logic               o_acc_we,
  output logic      [DW-1:0] o_acc_wdata,
  output logic               o_zero_we,
  output logic               o_zero,
  // Data memory write
  output logic               o_mem_we,
  output logic      [AW-1:0] o_mem_addr,
  output logic      [DW-1:0] o_mem_wdata,
  // Program flow
  output logic               o_stack_pop,
  output logic               o_stack_push,
  output logic               o_pc_load,
  output logic      [PW-1:0] o_pc_value,
  output logic               o_advance,
  // Interrupt gate
  output logic               o_global_interrupt_gate
);
  typedef struct packed {
    lrx_pkg::lrx_state_t state;
    logic                acc_we;
    logic [DW-1:0]       acc_wdata;
    logic                zero_we;
    logic                zero;
    logic                mem_we;
    logic [AW-1:0]       mem_addr;
    logic [DW-1:0]       mem_wdata;
    logic                pop;
    logic                push;
    logic                pc_load;
    logic [PW-1:0]       pc_value;
    logic                advance;
    logic                gate;
  } lrx_regs_t;

  // Field updates shared by several opcodes
  function automatic lrx_regs_t load_acc(lrx_regs_t     s,
                                         logic [DW-1:0] d);
    lrx_regs_t t;
    t           = s;
    t.acc_we    = 1'b1;
    t.acc_wdata = d;
    return t;
  endfunction

  function automatic lrx_regs_t set_zero(lrx_regs_t s,
                                         logic      z);
    lrx_regs_t t;
    t         = s;
    t.zero_we = 1'b1;
    t.zero    = z;
    return t;
  endfunction

  function automatic lrx_regs_t store_mem(lrx_regs_t     s,
                                          logic [AW-1:0] a,
                                          logic [DW-1:0] d);
    lrx_regs_t t;
    t           = s;
    t.mem_we    = 1'b1;
    t.mem_addr  = a;
    t.mem_wdata = d;
    return t;
  endfunction

  function automatic lrx_regs_t load_pc(lrx_regs_t     s,
                                        logic [PW-1:0] a);
    lrx_regs_t t;
    t          = s;
    t.pc_load  = 1'b1;
    t.pc_value = a;
    return t;
  endfunction

  // Return address leaves the stack as it is loaded
  function automatic lrx_regs_t pop_return(lrx_regs_t     s,
                                           logic [PW-1:0] a);
    lrx_regs_t t;
    t     = load_pc(s, a);
    t.pop = 1'b1;
    return t;
  endfunction

  lrx_regs_t r;
  lrx_regs_t next_r;
  logic [DW-1:0] or_res;
  logic          or_zero;
  logic [DW-1:0] rol_res;
  lrx_pkg::lrx_op_t op;

  assign op = lrx_pkg::lrx_op_t'(i_op);

  lrx_alu #(.DW(DW)) u_alu (
    .i_acc     (i_acc),
    .i_mem     (i_mem_rdata),
    .i_lit     (i_lit),
    .i_use_lit (op == lrx_pkg::LRX_OP_ORI),
    .o_or      (or_res),
    .o_zero    (or_zero),
    .o_rol     (rol_res)
  );

  always_comb begin
    next_r           = r;
    next_r.acc_we    = 1'b0;
    next_r.zero_we   = 1'b0;
    next_r.mem_we    = 1'b0;
    next_r.pop       = 1'b0;
    next_r.push      = 1'b0;
    next_r.pc_load   = 1'b0;
    next_r.advance   = 1'b0;
    next_r.state     = lrx_pkg::LRX_ST_IDLE;
    case (r.state)
      lrx_pkg::LRX_ST_IDLE: begin
        if (i_valid) begin
          next_r.advance = 1'b1;
          case (op)
            lrx_pkg::LRX_OP_NOP: begin
              next_r.advance = 1'b1;
            end
            lrx_pkg::LRX_OP_ORM: begin
              next_r = load_acc(next_r, or_res);
              next_r = set_zero(next_r, or_zero);
            end
            lrx_pkg::LRX_OP_ORI: begin
              next_r = load_acc(next_r, or_res);
              next_r = set_zero(next_r, or_zero);
            end
            lrx_pkg::LRX_OP_ORMM: begin
              next_r = store_mem(next_r, i_addr, or_res);
              next_r = set_zero(next_r, or_zero);
            end
            lrx_pkg::LRX_OP_RET: begin
              next_r.advance = 1'b0;
              next_r = pop_return(next_r, i_stack_top);
            end
            lrx_pkg::LRX_OP_RETL: begin
              next_r.advance = 1'b0;
              next_r = pop_return(next_r, i_stack_top);
              next_r = load_acc(next_r, i_lit);
            end
            lrx_pkg::LRX_OP_INTERRUPT_RETURN_OP: begin
              next_r.advance = 1'b0;
              next_r.gate    = `LRX_GATE_ON;
              if (i_irq_pending) begin
                // Keep return address stacked, enter handler directly
                next_r = load_pc(next_r, PW'(`LRX_ISR_VECTOR));
              end else begin
                next_r = pop_return(next_r, i_stack_top);
              end
            end
            lrx_pkg::LRX_OP_RLM: begin
              next_r = store_mem(next_r, i_addr, rol_res);
            end
            default: begin
              next_r.advance = 1'b0;
            end
          endcase
        end
      end
      lrx_pkg::LRX_ST_WRITE: begin
        next_r.state = lrx_pkg::LRX_ST_IDLE;
      end
      default: begin
        next_r.state = lrx_pkg::LRX_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r           <= '0;
      r.state     <= lrx_pkg::LRX_ST_IDLE;
      r.zero      <= 1'b0;
      r.gate      <= `LRX_GATE_RST;
      r.acc_wdata <= `LRX_ZERO_BYTE;
      r.mem_wdata <= `LRX_ZERO_BYTE;
    end else begin
      r <= next_r;
    end
  end

  assign o_acc_we                = r.acc_we;
  assign o_acc_wdata             = r.acc_wdata;
  assign o_zero_we               = r.zero_we;
  assign o_zero                  = r.zero;
  assign o_mem_we                = r.mem_we;
  assign o_mem_addr              = r.mem_addr;
  assign o_mem_wdata             = r.mem_wdata;
  assign o_stack_pop             = r.pop;
  assign o_stack_push            = r.push;
  assign o_pc_load               = r.pc_load;
  assign o_pc_value              = r.pc_value;
  assign o_advance               = r.advance;
  assign o_global_interrupt_gate = r.gate;
endmodule

// >>> verif/lrx_sva.sv
// Port assertions for the execution block
`timescale 1ns/1ps
`include "lrx_params.svh"
module lrx_sva #(
  parameter int DW = `LRX_DATA_W,
  parameter int AW = `LRX_ADDR_W,
  parameter int PW = `LRX_PC_W
) (
  // Inputs
  input logic          i_clk,
  input logic          i_arst_n,
  input logic          i_valid,
  input logic [3:0]    i_op,
  input logic [DW-1:0] i_lit,
  input logic [AW-1:0] i_addr,
  input logic [DW-1:0] i_acc,
  input logic [DW-1:0] i_mem_rdata,
  input logic [PW-1:0] i_stack_top,
  input logic          i_irq_pending,
  // Outputs
  input logic          o_acc_we,
  input logic [DW-1:0] o_acc_wdata,
  input logic          o_zero_we,
  input logic          o_zero,
  input logic          o_mem_we,
  input logic [AW-1:0] o_mem_addr,
  input logic [DW-1:0] o_mem_wdata,
  input logic          o_stack_pop,
  input logic          o_stack_push,
  input logic          o_pc_load,
  input logic [PW-1:0] o_pc_value,
  input logic          o_advance,
  input logic          o_global_interrupt_gate
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_nop_quiet: assert property (i_valid && i_op == 4'h1 |=>
    o_advance && !(o_acc_we || o_mem_we || o_zero_we || o_pc_load))
    else $error("nop");
  a_or_acc: assert property (i_valid && i_op == 4'h2 |=>
    o_acc_we && !o_mem_we
    && o_acc_wdata == ($past(i_acc) | $past(i_mem_rdata))) else $error("or");
  a_zero_flag: assert property (i_valid && i_op == 4'h2 |=>
    o_zero_we && o_zero == (($past(i_acc) | $past(i_mem_rdata)) == '0))
    else $error("zero");
  a_or_lit: assert property (i_valid && i_op == 4'h3 |=>
    o_acc_we && o_zero_we && !o_mem_we
    && o_acc_wdata == ($past(i_acc) | $past(i_lit))) else $error("ori");
  a_or_mem: assert property (i_valid && i_op == 4'h4 |=>
    o_mem_we && !o_acc_we && o_zero_we && o_mem_addr == $past(i_addr)
    && o_mem_wdata == ($past(i_acc) | $past(i_mem_rdata))
    && o_zero == (o_mem_wdata == '0)) else $error("orm");
  a_ret_pop: assert property (i_valid && i_op == 4'h5 |=>
    o_stack_pop && o_pc_value == $past(i_stack_top) && !o_zero_we)
    else $error("ret");
  a_ret_lit: assert property (i_valid && i_op == 4'h6 |=>
    o_pc_load && o_acc_wdata == $past(i_lit) && !o_zero_we) else $error("retl");
  a_interrupt_return_op_gate: assert property (i_valid && i_op == 4'h7 |=>
    o_global_interrupt_gate && o_pc_load && !o_zero_we) else $error("interrupt_return_op");
  a_interrupt_return_op_pend: assert property (
    i_valid && i_op == 4'h7 && i_irq_pending |=>
    !o_stack_pop && o_pc_value == `LRX_ISR_VECTOR) else $error("pend");
  a_rotate_mem: assert property (i_valid && i_op == 4'h8 |=>
    o_mem_we && !o_zero_we && o_mem_wdata ==
    {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])}) else $error("rl");
endmodule
bind lrx_exec lrx_sva #(.DW(DW), .AW(AW), .PW(PW)) u_sva (.*);

// >>> verif/tb.sv
// Self-checking bench for the execution block
`timescale 1ns/1ps
`include "lrx_params.svh"
module tb;
  logic        i_clk = 1'h0, i_arst_n = 1'h0, i_valid = 1'h0;
  logic        i_irq_pending = 1'h0;
  logic [3:0]  i_op = 4'h0;
  logic [7:0]  i_lit = 8'h00, i_addr = 8'h2D, i_acc = 8'h00;
  logic [7:0]  i_mem_rdata = 8'h00;
  logic [12:0] i_stack_top = 13'h1ABC;
  logic        o_acc_we, o_zero_we, o_zero, o_mem_we, o_stack_pop;
  logic        o_stack_push, o_pc_load, o_advance, o_global_interrupt_gate;
  logic [7:0]  o_acc_wdata, o_mem_addr, o_mem_wdata;
  logic [12:0] o_pc_value;
  int          n_mismatch = 0, checks_done = 0;
  lrx_exec dut_u (.*);
  always #50 i_clk = ~i_clk;
  task automatic chk(string n, logic [12:0] e, logic [12:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic issue(logic [3:0] op, logic [7:0] a, m, l, logic q);
    @(posedge i_clk);
    i_op <= op;
    i_acc <= a;
    i_mem_rdata <= m;
    i_lit <= l;
    i_irq_pending <= q;
    i_valid <= 1'h1;
    @(posedge i_clk);
    i_valid <= 1'h0;
    #1;
  endtask
  task automatic t_nop;
    issue(4'h1, 8'hFF, 8'hFF, 8'hFF, 1'h0);
    chk("nop", 4'h8, {o_advance, o_acc_we, o_mem_we, o_zero_we});
  endtask
  task automatic t_or;
    issue(4'h2, 8'h50, 8'h0A, 8'hFF, 1'h0);
    chk("acc", 8'h5A, o_acc_wdata);
    chk("we", 4'hC, {o_acc_we, o_zero_we, o_mem_we, o_zero});
    issue(4'h2, 8'h00, 8'h00, 8'hFF, 1'h0);
    chk("zero", 1'h1, o_zero);
    issue(4'h3, 8'h01, 8'hFF, 8'h80, 1'h0);
    chk("acc", 8'h81, o_acc_wdata);
    chk("we", 3'h6, {o_acc_we, o_zero_we, o_mem_we});
    issue(4'h4, 8'h0C, 8'h30, 8'hFF, 1'h0);
    chk("mem", 8'h3C, o_mem_wdata);
    chk("addr", 8'h2D, o_mem_addr);
    chk("we", 3'h3, {o_acc_we, o_zero_we, o_mem_we});
  endtask
  task automatic t_ret;
    chk("gate", 1'h0, o_global_interrupt_gate);
    issue(4'h5, 8'h11, 8'h00, 8'h22, 1'h0);
    chk("pc", 13'h1ABC, o_pc_value);
    chk("pop", 3'h6, {o_stack_pop, o_pc_load, o_zero_we});
    issue(4'h6, 8'h11, 8'h00, 8'h7E, 1'h0);
    chk("acc", 8'h7E, o_acc_wdata);
    chk("pop", 4'hD, {o_stack_pop, o_pc_load, o_zero_we, o_acc_we});
    issue(4'h7, 8'h11, 8'h00, 8'h00, 1'h0);
    chk("gate", 1'h1, o_global_interrupt_gate);
    chk("interrupt_return_op", 2'h3, {o_stack_pop, o_pc_load});
    issue(4'h7, 8'h11, 8'h00, 8'h00, 1'h1);
    chk("vec", `LRX_ISR_VECTOR, o_pc_value);
    chk("pop", 1'h0, o_stack_pop);
    chk("push", 1'h0, o_stack_push);
  endtask
  task automatic t_rl;
    issue(4'h8, 8'h00, 8'h81, 8'h00, 1'h0);
    chk("rot", 8'h03, o_mem_wdata);
    chk("we", 3'h1, {o_acc_we, o_zero_we, o_mem_we});
    issue(4'h8, 8'h00, 8'h40, 8'h00, 1'h0);
    chk("rot", 8'h80, o_mem_wdata);
    issue(4'hF, 8'h00, 8'h40, 8'h00, 1'h0);
    chk("bad", 2'h0, {o_advance, o_mem_we});
  endtask
  task automatic t_reset;
    @(posedge i_clk);
    i_arst_n <= 1'h0;
    #1;
    chk("rst", 2'h0, {o_global_interrupt_gate, o_advance});
    @(posedge i_clk);
    i_arst_n <= 1'h1;
    issue(4'h1, 8'hFF, 8'hFF, 8'hFF, 1'h0);
    chk("nop", 4'h8, {o_advance, o_acc_we, o_mem_we, o_zero_we});
    chk("gate", 1'h0, o_global_interrupt_gate);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'h1;
    t_nop;
    t_or;
    t_ret;
    t_rl;
    t_reset;
    print_verdict;
  end
  initial begin
    #100000;
    n_mismatch++;
    print_verdict;
  end
endmodule
